// file: src/bbp_defs.svh
// Constant definitions for the boolean bit processor.
`ifndef BBP_DEFS_SVH
`define BBP_DEFS_SVH
`define BBP_RAM_BIT_BASE    8'h20
`define BBP_SFR_P0          8'h80
`define BBP_SFR_TCS         8'h88
`define BBP_SFR_P1          8'h90
`define BBP_SFR_SCS         8'h98
`define BBP_SFR_P2          8'hA0
`define BBP_SFR_P3          8'hB0
`define BBP_SFR_PSW         8'hD0
`define BBP_SFR_ACC         8'hE0
`define BBP_SFR_BREG        8'hF0
`define BBP_TCS_T1_OVF      7
`define BBP_TCS_T1_RUN      6
`define BBP_TCS_T0_OVF      5
`define BBP_TCS_T0_RUN      4
`define BBP_SCS_MODE_HI     7
`define BBP_SCS_MODE_LO     6
`define BBP_SCS_MP_FILTER   5
`define BBP_SCS_RX_EN       4
`define BBP_SCS_TX_NINTH    3
`define BBP_SCS_RX_NINTH    2
`define BBP_SCS_TX_DONE     1
`define BBP_SCS_RX_DONE     0
`define BBP_PSW_CARRY       7
`define BBP_PORT_RESET      8'hFF
`define BBP_REG_RESET       8'h00
`endif

// file: src/bbp_pkg.sv
// Types shared by the boolean bit processor.
package bbp_pkg;
  typedef enum logic [3:0] {
    BBP_OP_NOP    = 4'h0,
    BBP_OP_SET    = 4'h1,
    BBP_OP_CLR    = 4'h2,
    BBP_OP_INV    = 4'h3,
    BBP_OP_MOV_C  = 4'h4,
    BBP_OP_MOV_B  = 4'h5,
    BBP_OP_AND    = 4'h6,
    BBP_OP_OR     = 4'h7,
    BBP_OP_JC     = 4'h8,
    BBP_OP_JNC    = 4'h9,
    BBP_OP_JB     = 4'hA,
    BBP_OP_JNB    = 4'hB,
    BBP_OP_JBC    = 4'hC,
    BBP_OP_SHORT_RELATIVE_JUMP   = 4'hD
  } bbp_op_type;

  typedef enum logic [1:0] {
    BBP_SER_SHIFT = 2'b00,
    BBP_SER_UART8 = 2'b01,
    BBP_SER_UART9F = 2'b10,
    BBP_SER_UART9V = 2'b11
  } bbp_ser_mode_type;

  typedef enum logic [0:0] {
    BBP_ST_IDLE = 1'b0,
    BBP_ST_SECOND = 1'b1
  } bbp_state_type;

  typedef struct packed {
    bbp_op_type  op;
    logic        on_carry;
    logic        invert_src;
    logic [7:0]  bit_addr;
    logic [7:0]  rel;
  } bbp_instr_type;

  typedef struct packed {
    logic        t1_ovf;
    logic        t0_ovf;
    logic        t1_ack;
    logic        t0_ack;
    logic        tx_done;
    logic        rx_done;
    logic        rx_ninth;
    logic        rx_ninth_we;
  } bbp_periph_evt_type;

  typedef struct packed {
    logic        psw_we;
    logic [7:0]  psw_data;
    logic        carry_we;
    logic        carry_data;
  } bbp_alu_wr_type;
endpackage

// file: src/bbp_core.sv
// Boolean bit processor: bit space, bit instructions and relative jumps.
// ============================================================
`include "bbp_defs.svh"
module bbp_core
  import bbp_pkg::*;
#(
  parameter int PC_W = 16
)(
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic               instr_valid,
  input  wire bbp_instr_type      instr,
  input  wire logic [PC_W-1:0]    pc_next,
  input  wire bbp_periph_evt_type evt,
  input  wire bbp_alu_wr_type     alu_wr,
  input  wire logic [31:0]        port_pins,
  output logic                    instr_ready,
  output logic                    jump_taken,
  output logic [PC_W-1:0]         jump_target,
  output logic                    carry_flag,
  output logic [7:0]              program_status_word,
  output logic [7:0]              timer_control_status,
  output logic [7:0]              serial_control_status,
  output logic [7:0]              acc_out,
  output logic [7:0]              breg_out,
  output logic [31:0]             port_latch,
  output logic                    timer1_run,
  output logic                    timer0_run,
  output bbp_ser_mode_type        serial_mode,
  output logic                    rx_accept,
  output logic                    tx_ninth_bit
);

  // ============================================================
  // Storage
  logic [7:0]  ram_r [16];
  logic [7:0]  psw_r;
  logic [7:0]  tcs_r;
  logic [7:0]  scs_r;
  logic [7:0]  acc_r;
  logic [7:0]  breg_r;
  logic [31:0] port_r;
  logic [31:0] pin_s1_r;
  logic [31:0] pin_s2_r;
  bbp_state_type  state_r;
  bbp_instr_type  held_r;

  // ============================================================
  // Decode
  // Two-cycle instructions are captured and finish in the second cycle.
  wire two_cycle = (instr.op == BBP_OP_MOV_B) || (instr.op >= BBP_OP_JC);
  wire issue     = instr_valid && (state_r == BBP_ST_IDLE);
  wire finish    = (state_r == BBP_ST_SECOND);
  wire bbp_instr_type cur = finish ? held_r : instr;
  wire do_op     = (issue && !two_cycle) || finish;
  wire [7:0]  addr     = cur.bit_addr;
  wire [2:0]  bit_pos  = addr[2:0];
  wire [7:0]  sfr_base = {addr[7:3], 3'b000};
  wire        is_ram   = !addr[7];

  function automatic logic [7:0] bit_apply(input logic [7:0] v, input logic [2:0] p,
                                           input logic b);
    logic [7:0] r;
    r = v;
    r[p] = b;
    return r;
  endfunction

  // Ports read the pin for tests; writes go through the latch.
  wire [7:0] pin_byte = (sfr_base == `BBP_SFR_P0) ? pin_s2_r[7:0] :
                        (sfr_base == `BBP_SFR_P1) ? pin_s2_r[15:8] :
                        (sfr_base == `BBP_SFR_P2) ? pin_s2_r[23:16] : pin_s2_r[31:24];
  wire [1:0] port_idx = (sfr_base == `BBP_SFR_P0) ? 2'd0 :
                        (sfr_base == `BBP_SFR_P1) ? 2'd1 :
                        (sfr_base == `BBP_SFR_P2) ? 2'd2 : 2'd3;
  wire is_port = (sfr_base == `BBP_SFR_P0) || (sfr_base == `BBP_SFR_P1) ||
                 (sfr_base == `BBP_SFR_P2) || (sfr_base == `BBP_SFR_P3);
  wire [7:0] latch_byte = port_r[{port_idx, 3'b000} +: 8];
  // Bit instructions that modify a port read the latch, not the pin.
  wire rmw_op = (cur.op == BBP_OP_SET) || (cur.op == BBP_OP_CLR) ||
                (cur.op == BBP_OP_INV) || (cur.op == BBP_OP_MOV_B) ||
                (cur.op == BBP_OP_JBC);

  wire [7:0] ram_byte = ram_r[addr[6:3]];
  wire [7:0] sel_byte = is_ram ? ram_byte :
                        (sfr_base == `BBP_SFR_PSW)  ? psw_r :
                        (sfr_base == `BBP_SFR_ACC)  ? acc_r :
                        (sfr_base == `BBP_SFR_BREG) ? breg_r :
                        (sfr_base == `BBP_SFR_TCS)  ? tcs_r :
                        (sfr_base == `BBP_SFR_SCS)  ? scs_r :
                        is_port ? (rmw_op ? latch_byte : pin_byte) : 8'h00;
  wire src_bit = sel_byte[bit_pos];
  wire carry   = psw_r[`BBP_PSW_CARRY];

  wire new_bit = (cur.op == BBP_OP_SET) ? 1'b1 :
                 (cur.op == BBP_OP_CLR) ? 1'b0 :
                 (cur.op == BBP_OP_INV) ? !(cur.on_carry ? carry : src_bit) :
                 (cur.op == BBP_OP_MOV_B) ? carry : 1'b0;
  wire bitop  = (cur.op == BBP_OP_SET) || (cur.op == BBP_OP_CLR) || (cur.op == BBP_OP_INV);
  wire operand = cur.invert_src ? !src_bit : src_bit;

  wire cond = (cur.op == BBP_OP_JC)  ?  carry :
              (cur.op == BBP_OP_JNC) ? !carry :
              (cur.op == BBP_OP_JB)  ?  src_bit :
              (cur.op == BBP_OP_JNB) ? !src_bit :
              (cur.op == BBP_OP_JBC) ?  src_bit :
              (cur.op == BBP_OP_SHORT_RELATIVE_JUMP);
  // clear only when the bit was set
  wire jbc_clear = finish && (cur.op == BBP_OP_JBC) && src_bit;

  // Carry result for the carry-targeted forms.
  wire c_we = do_op && ((bitop && cur.on_carry) || cur.op == BBP_OP_MOV_C ||
                        cur.op == BBP_OP_AND || cur.op == BBP_OP_OR);
  // carry logic with true or inverted operand
  wire c_val = (cur.op == BBP_OP_MOV_C) ? src_bit :
               (cur.op == BBP_OP_AND) ? (carry & operand) :
               (cur.op == BBP_OP_OR)  ? (carry | operand) : new_bit;
  // Destination bit write.
  wire b_we  = (do_op && ((bitop && !cur.on_carry) || cur.op == BBP_OP_MOV_B)) || jbc_clear;
  wire b_val = jbc_clear ? 1'b0 : new_bit;
  wire [7:0] wr_byte = bit_apply(sel_byte, bit_pos, b_val);

  // Pure function of its arguments, so the continuous assignments that
  // use it re-evaluate whenever any of its inputs moves.
  function automatic logic hit(input logic we, input logic [7:0] at, input logic [7:0] base);
    return we && (at == base);
  endfunction

  // The accumulator, B and the port latches change only when a bit write is aimed at them.
  wire sfr_we   = b_we && !is_ram;
  wire hit_psw  = hit(sfr_we, sfr_base, `BBP_SFR_PSW);
  wire hit_tcs  = hit(sfr_we, sfr_base, `BBP_SFR_TCS);
  wire hit_scs  = hit(sfr_we, sfr_base, `BBP_SFR_SCS);
  wire hit_acc  = hit(sfr_we, sfr_base, `BBP_SFR_ACC);
  wire hit_breg = hit(sfr_we, sfr_base, `BBP_SFR_BREG);

  // displacement is sign extended and added to pc
  wire [PC_W-1:0] disp = PC_W'($signed(cur.rel));

  // ============================================================
  // Sequencer
  // The held copy lets the offered instruction change during the busy
  // cycle without disturbing the second half of a two-cycle instruction.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= BBP_ST_IDLE;
      held_r  <= '0;
    end
    else
    begin
      state_r <= (issue && two_cycle) ? BBP_ST_SECOND : BBP_ST_IDLE;
      if (issue)
        held_r <= instr;
    end
  end

  // The target is recomputed every cycle and means something only while
  // jump_taken is high.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      jump_taken  <= 1'b0;
      jump_target <= '0;
    end
    else
    begin
      jump_taken  <= finish && cond && (cur.op >= BBP_OP_JC);
      jump_target <= pc_next + disp;
    end
  end

  // Pins come from outside the clock domain.
  // The synchroniser starts at zero, so a pin test right after reset can
  // see a low level for two cycles even on a pin that is held high.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ============================================================
  // Bit space registers
  // The bit RAM has no reset; software must initialise its flags.
  always_ff @(posedge core_clk)
  begin
    if (b_we && is_ram)
      ram_r[addr[6:3]] <= wr_byte;
  end

  // core byte writes and side effects, bit writes win
  wire [2:0] carry_pos = 3'(`BBP_PSW_CARRY);
  wire [7:0] psw_base = alu_wr.psw_we ? alu_wr.psw_data :
                        alu_wr.carry_we ? bit_apply(psw_r, carry_pos, alu_wr.carry_data)
                        : psw_r;
  wire [7:0] psw_bitw = hit_psw ? bit_apply(psw_base, bit_pos, b_val) : psw_base;
  // A carry-targeted result is applied last so that it beats a core byte
  // write of the status word in the same cycle.
  wire [7:0] psw_nxt  = c_we ? bit_apply(psw_bitw, carry_pos, c_val) : psw_bitw;

  // timer flags: hardware set beats clear in the same cycle
  wire [7:0] tcs_w = hit_tcs ? wr_byte : tcs_r;
  wire [7:0] tcs_nxt = {tcs_w[7] & !evt.t1_ack | evt.t1_ovf, tcs_w[6],
                        tcs_w[5] & !evt.t0_ack | evt.t0_ovf, tcs_w[4], tcs_w[3:0]};
  wire [7:0] scs_w = hit_scs ? wr_byte : scs_r;
  wire [7:0] scs_nxt = {scs_w[7:3],
                        evt.rx_ninth_we ? evt.rx_ninth : scs_w[2],
                        scs_w[1] | evt.tx_done,
                        scs_w[0] | evt.rx_done};

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      psw_r  <= `BBP_REG_RESET;
      tcs_r  <= `BBP_REG_RESET;
      scs_r  <= `BBP_REG_RESET;
      acc_r  <= `BBP_REG_RESET;
      breg_r <= `BBP_REG_RESET;
      port_r <= {4{`BBP_PORT_RESET}};
    end
    else
    begin
      psw_r <= psw_nxt;
      tcs_r <= tcs_nxt;
      scs_r <= scs_nxt;
      if (hit_acc)
        acc_r <= wr_byte;
      if (hit_breg)
        breg_r <= wr_byte;
      if (b_we && !is_ram && is_port)
        port_r[{port_idx, 3'b000} +: 8] <= wr_byte;
    end
  end

  // ============================================================
  // Outputs
  assign instr_ready           = (state_r == BBP_ST_IDLE);
  assign carry_flag            = psw_r[`BBP_PSW_CARRY];
  assign program_status_word   = psw_r;
  assign timer_control_status  = tcs_r;
  assign serial_control_status = scs_r;
  assign acc_out               = acc_r;
  assign breg_out              = breg_r;
  assign port_latch            = port_r;
  assign timer1_run            = tcs_r[`BBP_TCS_T1_RUN];
  assign timer0_run            = tcs_r[`BBP_TCS_T0_RUN];
  assign serial_mode = bbp_ser_mode_type'(scs_r[`BBP_SCS_MODE_HI:`BBP_SCS_MODE_LO]);
  assign rx_accept = scs_r[`BBP_SCS_RX_EN] &&
                     !(scs_r[`BBP_SCS_MP_FILTER] && scs_r[`BBP_SCS_MODE_HI] && !evt.rx_ninth);
  assign tx_ninth_bit = scs_r[`BBP_SCS_TX_NINTH];

  // ============================================================
  // Checks
  AST_TX_DONE_STICKY: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt.tx_done |=> serial_control_status[`BBP_SCS_TX_DONE])
    else $error("transmit done flag not set");
  AST_RX_DONE_STICKY: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt.rx_done |=> serial_control_status[`BBP_SCS_RX_DONE])
    else $error("receive done flag not set");
  AST_T1_OVF_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt.t1_ovf |=> timer_control_status[`BBP_TCS_T1_OVF])
    else $error("timer1 overflow flag not set");
  AST_TWO_CYCLE_BUSY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && two_cycle) |=> !instr_ready ##1 instr_ready)
    else $error("two cycle instruction timing wrong");
  AST_SHORT_RELATIVE_JUMP_TAKEN: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && instr.op == BBP_OP_SHORT_RELATIVE_JUMP) |-> ##2 jump_taken)
    else $error("short jump not taken");
  AST_JC_CARRY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (finish && cur.op == BBP_OP_JC) |=> (jump_taken == $past(carry)))
    else $error("carry jump wrong");
  AST_SET_CARRY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (issue && instr.op == BBP_OP_SET && instr.on_carry && !alu_wr.psw_we) |=> carry_flag)
    else $error("carry not set");
  AST_JBC_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
    (jbc_clear && is_ram) |=> !ram_r[$past(addr[6:3])][$past(bit_pos)])
    else $error("jump and clear left bit set");
  AST_RX_NINTH: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt.rx_ninth_we |=> (serial_control_status[`BBP_SCS_RX_NINTH] == $past(evt.rx_ninth)))
    else $error("receive ninth bit not loaded");

  // Further checks on flags, branches, the port latch, the accumulator source and the receive filter.
  AST_T0_OVF_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt.t0_ovf |=> timer_control_status[`BBP_TCS_T0_OVF])
    else $error("timer0 overflow flag not set");
  AST_JNC_CARRY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (finish && cur.op == BBP_OP_JNC) |=> (jump_taken == !$past(carry)))
    else $error("no carry jump wrong");
  AST_JB_BIT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (finish && cur.op == BBP_OP_JB) |=> (jump_taken == $past(src_bit)))
    else $error("bit jump wrong");
  AST_JUMP_TARGET: assert property (@(posedge core_clk) disable iff (!rst_b)
    jump_taken |-> (jump_target == $past(pc_next) + $past(disp)))
    else $error("jump target wrong");
  AST_MOV_TO_CARRY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (do_op && cur.op == BBP_OP_MOV_C) |=> (carry_flag == $past(src_bit)))
    else $error("bit not moved to carry");
  AST_SRC_KEPT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (do_op && (cur.op == BBP_OP_AND || cur.op == BBP_OP_OR) && sfr_base == `BBP_SFR_ACC)
    |=> $stable(acc_out))
    else $error("logic source bit changed");
  AST_PORT_ONE_BIT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sfr_we && is_port) |=> ($countones(port_latch ^ $past(port_latch)) <= 1))
    else $error("port write touched more than one latch bit");
  AST_RX_FILTER: assert property (@(posedge core_clk) disable iff (!rst_b)
    (serial_control_status[`BBP_SCS_MP_FILTER] && serial_control_status[`BBP_SCS_MODE_HI] &&
     !evt.rx_ninth) |-> !rx_accept)
    else $error("filtered frame accepted");

endmodule

// file: testbench/testbench.sv
// Self-checking testbench for the boolean bit processor core.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;

  logic               core_clk;
  logic               rst_b;
  logic               instr_valid;
  bbp_instr_type      instr;
  logic [15:0]        pc_next;
  bbp_periph_evt_type evt;
  bbp_alu_wr_type     alu_wr;
  logic [31:0]        port_pins;
  logic               instr_ready;
  logic               jump_taken;
  logic [15:0]        jump_target;
  logic               carry_flag;
  logic [7:0]         program_status_word;
  logic [7:0]         timer_control_status;
  logic [7:0]         serial_control_status;
  logic [7:0]         acc_out;
  logic [7:0]         breg_out;
  logic [31:0]        port_latch;
  logic               timer1_run;
  logic               timer0_run;
  bbp_ser_mode_type   serial_mode;
  logic               rx_accept;
  logic               tx_ninth_bit;
  int                 miscompares = 0;
  int                 compares = 0;
  int                 cyc = 0;

  bbp_core dut_u (
    .core_clk, .rst_b, .instr_valid, .instr, .pc_next, .evt, .alu_wr, .port_pins,
    .instr_ready, .jump_taken, .jump_target, .carry_flag, .program_status_word,
    .timer_control_status, .serial_control_status, .acc_out, .breg_out, .port_latch,
    .timer1_run, .timer0_run, .serial_mode, .rx_accept, .tx_ninth_bit
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ============================================================
  // Helper tasks
  task automatic finish_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run with no verdict.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Valid is held through the busy cycle; the core ignores it then, and a
  // new offer in the same step as a release would race the sampling edge.
  task automatic op(input bbp_op_type o, input logic c, input logic [7:0] a,
                    input logic [7:0] r = 8'h00, input logic v = 1'b0);
    instr_valid = 1'b1;
    instr = '{op: o, on_carry: c, invert_src: v, bit_addr: a, rel: r};
    @(posedge core_clk);
    @(negedge core_clk);
    if (o == BBP_OP_MOV_B || o >= BBP_OP_JC)
    begin
      chk(instr_ready, 1'b0, "ready in busy cycle");
      @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask

  task automatic idle(input int n);
    if (instr_valid)
      instr_valid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask

  task automatic jmp(input bbp_op_type o, input logic c, input logic [7:0] a,
                     input logic [7:0] r, input logic t);
    pc_next = {a, 8'h05};
    op(o, c, a, r);
    chk(jump_taken, t, "jump taken");
    if (t)
      chk(jump_target, 16'(pc_next + {{8{r[7]}}, r}), "jump target");
  endtask

  task automatic side(input bbp_periph_evt_type e, input bbp_alu_wr_type w);
    idle(0);
    evt = e;
    alu_wr = w;
    @(posedge core_clk);
    @(negedge core_clk);
    evt = '0;
    alu_wr = '0;
    idle(1);
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    pc_next = 16'h0000;
    evt = '0;
    alu_wr = '0;
    port_pins = 32'hFFFF_FFFF;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    chk({acc_out, breg_out, program_status_word}, 24'h0, "reset regs");
    chk({timer_control_status, serial_control_status}, 16'h0, "reset ctl");
    chk(port_latch, 32'hFFFF_FFFF, "reset latch");
    chk({instr_ready, jump_taken}, 2'b10, "reset hs");
    op(BBP_OP_SET, 1'b1, 8'h00);
    chk(program_status_word, 8'h80, "set carry");
    op(BBP_OP_INV, 1'b1, 8'h00);
    chk(carry_flag, 1'b0, "inv carry");
    for (int i = 0; i < 8; i++)
      op(BBP_OP_SET, 1'b0, 8'(8'hE0 + i));
    op(BBP_OP_CLR, 1'b0, 8'hE3);
    chk(acc_out, 8'hF7, "acc bits");
    op(BBP_OP_INV, 1'b0, 8'hF7);
    op(BBP_OP_SET, 1'b0, 8'hF0);
    chk(breg_out, 8'h81, "b bits");
    op(BBP_OP_MOV_C, 1'b0, 8'hE4);
    chk(carry_flag, 1'b1, "bit to carry");
    op(BBP_OP_MOV_B, 1'b0, 8'hF5);
    chk(breg_out, 8'hA1, "carry to bit");
    op(BBP_OP_AND, 1'b0, 8'hE3);
    chk(carry_flag, 1'b0, "and true");
    op(BBP_OP_OR, 1'b0, 8'hE3, 8'h00, 1'b1);
    chk(carry_flag, 1'b1, "or inverted");
    op(BBP_OP_AND, 1'b0, 8'hE4, 8'h00, 1'b1);
    chk(carry_flag, 1'b0, "and inverted");
    op(BBP_OP_OR, 1'b0, 8'hE4);
    chk({carry_flag, acc_out}, 9'h1F7, "or true");
    jmp(BBP_OP_JC, 1'b1, 8'h00, 8'h00, 1'b1);
    jmp(BBP_OP_JNC, 1'b1, 8'h00, 8'h10, 1'b0);
    jmp(BBP_OP_JB, 1'b0, 8'hE4, 8'h7F, 1'b1);
    jmp(BBP_OP_JNB, 1'b0, 8'hE4, 8'h7F, 1'b0);
    jmp(BBP_OP_JB, 1'b0, 8'hE3, 8'h80, 1'b0);
    jmp(BBP_OP_JNB, 1'b0, 8'hE3, 8'h80, 1'b1);
    jmp(BBP_OP_SHORT_RELATIVE_JUMP, 1'b0, 8'h00, 8'h80, 1'b1);
    jmp(BBP_OP_JBC, 1'b0, 8'hE4, 8'h01, 1'b1);
    chk(acc_out, 8'hE7, "jump clears bit");
    jmp(BBP_OP_JBC, 1'b0, 8'hE4, 8'h01, 1'b0);
    op(BBP_OP_CLR, 1'b1, 8'h00);
    jmp(BBP_OP_JNC, 1'b1, 8'h00, 8'hFE, 1'b1);
    jmp(BBP_OP_JC, 1'b1, 8'h00, 8'hFE, 1'b0);
    op(BBP_OP_SET, 1'b0, 8'h05);
    op(BBP_OP_CLR, 1'b0, 8'h7F);
    jmp(BBP_OP_JB, 1'b0, 8'h05, 8'h10, 1'b1);
    jmp(BBP_OP_JNB, 1'b0, 8'h7F, 8'hF0, 1'b1);
    jmp(BBP_OP_JBC, 1'b0, 8'h05, 8'h02, 1'b1);
    jmp(BBP_OP_JB, 1'b0, 8'h05, 8'h02, 1'b0);
    side('0, 11'h554);
    chk({carry_flag, program_status_word}, 9'h055, "psw byte write");
    for (int i = 0; i < 8; i++)
      jmp(BBP_OP_JB, 1'b0, 8'(8'hD0 + i), 8'(i), 1'((8'h55 >> i) & 1));
    side('0, 11'h003);
    chk(program_status_word, 8'hD5, "carry side effect");
    side('0, 11'h002);
    chk(carry_flag, 1'b0, "carry side clear");
    op(BBP_OP_INV, 1'b0, 8'h92);
    op(BBP_OP_CLR, 1'b0, 8'hA7);
    chk(port_latch, 32'hFF7F_FBFF, "port latch");
    idle(0);
    port_pins = 32'hFFFF_FEFF;
    idle(3);
    jmp(BBP_OP_JNB, 1'b0, 8'h90, 8'h04, 1'b1);
    jmp(BBP_OP_JB, 1'b0, 8'h91, 8'h04, 1'b1);
    side(8'h80, '0);
    side(8'h40, '0);
    chk(timer_control_status, 8'hA0, "overflow set");
    side(8'h20, '0);
    chk(timer_control_status, 8'h20, "t1 serviced");
    side(8'h10, '0);
    chk(timer_control_status, 8'h00, "t0 serviced");
    op(BBP_OP_SET, 1'b0, 8'h8E);
    op(BBP_OP_SET, 1'b0, 8'h8C);
    chk({timer1_run, timer0_run, timer_control_status}, 10'h350, "runs on");
    op(BBP_OP_CLR, 1'b0, 8'h8E);
    chk({timer1_run, timer0_run, timer_control_status}, 10'h110, "t1 off");
    for (int m = 0; m < 4; m++)
    begin
      op(m[1] ? BBP_OP_SET : BBP_OP_CLR, 1'b0, 8'h9F);
      op(m[0] ? BBP_OP_SET : BBP_OP_CLR, 1'b0, 8'h9E);
      chk({serial_mode, serial_control_status[7:6]}, {2{m[1:0]}}, "mode");
    end
    op(BBP_OP_SET, 1'b0, 8'h9C);
    op(BBP_OP_SET, 1'b0, 8'h9D);
    idle(0);
    evt = 8'h02;
    idle(1);
    chk(rx_accept, 1'b1, "ninth one accepted");
    evt = 8'h00;
    idle(1);
    chk(rx_accept, 1'b0, "ninth zero rejected");
    op(BBP_OP_CLR, 1'b0, 8'h9F);
    chk(rx_accept, 1'b1, "no filter in 8-bit");
    op(BBP_OP_CLR, 1'b0, 8'h9C);
    chk(rx_accept, 1'b0, "receive inhibited");
    op(BBP_OP_SET, 1'b0, 8'h9B);
    chk(tx_ninth_bit, 1'b1, "tx ninth");
    side(8'h03, '0);
    chk(serial_control_status[2], 1'b1, "rx ninth one");
    side(8'h01, '0);
    chk(serial_control_status[2], 1'b0, "rx ninth zero");
    side(8'h0C, '0);
    idle(4);
    chk(serial_control_status[1:0], 2'b11, "done flags held");
    op(BBP_OP_CLR, 1'b0, 8'h99);
    chk(serial_control_status[1:0], 2'b01, "tx done cleared");
    op(BBP_OP_CLR, 1'b0, 8'h98);
    chk(serial_control_status[1:0], 2'b00, "rx done cleared");
    idle(2);
    finish_test();
  end
endmodule
